// *** rtl/lock_tune_defines.svh ***
// constants for the configuration lock and auto-tune sequencer
// assumes a 50 MHz clock and plain-port control from the panel logic
`ifndef LOCK_TUNE_DEFINES_SVH
`define LOCK_TUNE_DEFINES_SVH
`define CLK_HZ 50000000
`define LOCKOUT_MINUTES 10
`define LOCKOUT_CYCLES (64'(`LOCKOUT_MINUTES) * 64'h3C * 64'(`CLK_HZ))
`define MAX_WRONG_TRIES 3'h5
`define FACTORY_CODE 14'h0457
`define MASTER_OFFSET 14'h2328
`define CODE_ZERO 14'h0000
`define CYCLE_RESTRICTED 3'h6
`define CYCLE_CONTROL 3'h1
`define BLINK_CYCLES 32'h017D7840
`endif

// *** rtl/lock_tune_pkg.sv ***
// types shared by the lock and tune sequencer
// assumes the defines header is compiled alongside
package lock_tune_pkg;
    // protection level codes: restricted only, 5-6 .. 1-6, every cycle
    typedef enum logic [2:0] {
        prot_only_restricted = 3'h0,
        prot_five_six = 3'h1,
        prot_four_six = 3'h2,
        prot_three_six = 3'h3,
        prot_two_six = 3'h4,
        prot_one_six = 3'h5,
        every_cycle_level = 3'h6
    } protection_level_select_t;
    // tuning selection values
    typedef enum logic [2:0] {
        tune_off = 3'h0,
        quick_tuning_option = 3'h1,
        tune_full = 3'h2,
        tune_self = 3'h3,
        retune_then_adaptive_option = 3'h4,
        strict_adaptive_option = 3'h5
    } tuning_selection_t;
    // panel edit request
    typedef struct packed {
        logic valid;
        logic [2:0] cycle;
        logic is_code_entry;
        logic is_code_change;
        logic [13:0] value;
    } edit_req_t;
endpackage

// *** rtl/pulse_timer.sv ***
// down counter that raises done when a loaded count runs out
// assumes load and count are from the same clock domain
module pulse_timer
    import lock_tune_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // control
    input wire logic load_in,
    input wire logic [WIDTH-1:0] count_in,
    // status
    output logic busy_out,
    output logic done_out
);
    logic [WIDTH-1:0] cnt_reg, cnt_next; // remaining cycles
    logic busy_reg, busy_next; // counting
    logic done_reg, done_next; // one-cycle expiry pulse

    // next state: load restarts, otherwise count down to one, then stop with done
    always_comb
    begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (load_in)
        begin
            cnt_next = count_in;
            busy_next = 1'b1;
        end
        else if (busy_reg)
        begin
            if (cnt_reg <= WIDTH'(1))
            begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg - WIDTH'(1);
            end
        end
    end

    // registers only
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign busy_out = busy_reg;
    assign done_out = done_reg;
endmodule

// *** rtl/lock_tune_seq.sv ***
// configuration lock and auto-tune sequencer
// assumes panel requests, run/reset events and tuner status on clk_in
// Operation
// - seven protection levels from restricted to all
// - restricted cycle always protected
// - code entry shown first in protected cycle
// - protected parameters viewable, edits rejected
// - valid code comes from code change parameter
// - factory access code is 1111
// - five wrong codes lock entry ten minutes
// - serial low three digits plus 9000 master
// - quick/full done loads PID, selection off
// - indicator lit during quick or full tuning
// - on/off during tuning, then PID
// - self-adaptive tunes at enable unless reference
// - large deviation restarts tuning and acquisition
// - user quick/full tune discards reference
// - retune option tunes then becomes self-adaptive
// - strict adaptive also tunes on control reset
// - acquisition length scales with response time
`include "lock_tune_defines.svh"
module lock_tune_seq
    import lock_tune_pkg::*;
#(
    parameter longint LOCKOUT_CYC = `LOCKOUT_CYCLES,
    parameter int ACQ_SCALE = 4
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // panel side
    input wire edit_req_t edit_in,
    input wire logic [2:0] view_cycle_in,
    input wire logic [9:0] serial_low_in,
    input wire protection_level_select_t protection_level_select_in,
    input wire logic [2:0] tuning_selection_in,
    input wire logic tuning_selection_wr_in,
    // process side
    input wire logic run_enable_in,
    input wire logic control_reset_in,
    input wire logic tune_done_in,
    input wire logic deviation_in,
    input wire logic [23:0] response_time_in,
    // status
    output logic edit_accept_out,
    output logic edit_reject_out,
    output logic code_entry_first_out,
    output logic unlocked_out,
    output logic lockout_out,
    output logic [13:0] access_code_out,
    output logic [2:0] tuning_selection_out,
    output logic tuning_indicator_out,
    output logic onoff_mode_out,
    output logic pid_load_out,
    output logic tune_start_out,
    output logic ref_valid_out
);
    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_tune = 2'h1,
        st_acquire = 2'h2
    } tune_state_t;

    // lock state
    logic [13:0] code_reg, code_next; // stored access code
    logic unlock_reg, unlock_next; // user code accepted
    logic master_reg, master_next; // master code accepted
    logic [2:0] wrong_reg, wrong_next; // consecutive failures
    logic lock_reg, lock_next; // entry refused
    logic acc_reg, acc_next;
    logic rej_reg, rej_next;
    logic first_reg, first_next;
    // tune state
    tune_state_t st_reg, st_next;
    tuning_selection_t sel_reg, sel_next;
    logic adaptive_reg, adaptive_next; // tuning started by a self mode or the retune option
    logic ref_reg, ref_next; // reference data held
    logic pid_reg, pid_next;
    logic start_reg, start_next;
    logic ind_reg, ind_next;
    logic onoff_reg, onoff_next; // on/off action while tuning
    logic run_d_reg; // previous run enable, edge detection
    logic [31:0] blink_reg, blink_next;
    logic blink_on_reg, blink_on_next;
    // timers
    logic lock_load, lock_done, acq_load, acq_done;
    logic [63:0] lock_cnt;
    logic [31:0] acq_cnt;
    logic [13:0] master_code;
    logic protected_cyc;
    logic view_guarded; // displayed cycle is protected
    logic run_rise;

    // master code: low three serial digits plus 9000
    assign master_code = 14'(serial_low_in) + `MASTER_OFFSET;
    assign lock_cnt = 64'(LOCKOUT_CYC);
    assign acq_cnt = 32'(response_time_in) * 32'(ACQ_SCALE);
    assign run_rise = run_enable_in & ~run_d_reg;

    // protection decode: level k protects cycles from (6-k) upward
    function automatic logic guarded_cyc(input logic [2:0] cyc,
                                         input protection_level_select_t lvl);
        if (cyc == `CYCLE_RESTRICTED)
            return 1'b1;
        if (lvl == every_cycle_level)
            return 1'b1;
        if (lvl == prot_only_restricted)
            return 1'b0;
        return (cyc >= 3'(`CYCLE_RESTRICTED - lvl));
    endfunction

    // one decode for the edited and the displayed cycle, so they never disagree
    assign protected_cyc = guarded_cyc(edit_in.cycle, protection_level_select_in);
    assign view_guarded = guarded_cyc(view_cycle_in, protection_level_select_in);

    // lock next state; code entry resolved before edits of the cycle
    always_comb
    begin
        code_next = code_reg;
        unlock_next = unlock_reg;
        master_next = master_reg;
        wrong_next = wrong_reg;
        lock_next = lock_reg;
        acc_next = 1'b0;
        rej_next = 1'b0;
        lock_load = 1'b0;
        first_next = view_guarded;
        if (lock_done)
        begin
            lock_next = 1'b0;
            wrong_next = 3'h0;
        end
        if (edit_in.valid && edit_in.is_code_entry)
        begin
            if (lock_reg)
                rej_next = 1'b1;
            else if (edit_in.value == code_reg)
            begin
                unlock_next = 1'b1;
                wrong_next = 3'h0;
                acc_next = 1'b1;
            end
            else if (edit_in.value == master_code)
            begin
                master_next = 1'b1;
                wrong_next = 3'h0;
                acc_next = 1'b1;
            end
            else
            begin
                rej_next = 1'b1;
                unlock_next = 1'b0;
                master_next = 1'b0;
                if (wrong_reg == `MAX_WRONG_TRIES - 3'h1)
                begin
                    lock_next = 1'b1;
                    lock_load = 1'b1;
                    wrong_next = `MAX_WRONG_TRIES;
                end
                else
                    wrong_next = wrong_reg + 3'h1;
            end
        end
        else if (edit_in.valid && edit_in.is_code_change)
        begin
            // master code grants only the code change
            if ((unlock_reg || master_reg) && edit_in.value != `CODE_ZERO)
            begin
                code_next = edit_in.value;
                acc_next = 1'b1;
            end
            else
                rej_next = 1'b1;
        end
        else if (edit_in.valid)
        begin
            if (protected_cyc && !unlock_reg)
                rej_next = 1'b1;
            else
                acc_next = 1'b1;
        end
    end

    // lock registers
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            code_reg <= `FACTORY_CODE;
            unlock_reg <= 1'b0;
            master_reg <= 1'b0;
            wrong_reg <= 3'h0;
            lock_reg <= 1'b0;
            acc_reg <= 1'b0;
            rej_reg <= 1'b0;
            first_reg <= 1'b0;
        end
        else
        begin
            code_reg <= code_next;
            unlock_reg <= unlock_next;
            master_reg <= master_next;
            wrong_reg <= wrong_next;
            lock_reg <= lock_next;
            acc_reg <= acc_next;
            rej_reg <= rej_next;
            first_reg <= first_next;
        end
    end

    // tuning sequencer next state
    always_comb
    begin
        st_next = st_reg;
        sel_next = sel_reg;
        adaptive_next = adaptive_reg;
        ref_next = ref_reg;
        pid_next = 1'b0;
        start_next = 1'b0;
        acq_load = 1'b0;
        blink_next = blink_reg;
        blink_on_next = blink_on_reg;
        if (tuning_selection_wr_in)
        begin
            sel_next = tuning_selection_t'(tuning_selection_in);
            if (tuning_selection_in == quick_tuning_option ||
                tuning_selection_in == tune_full)
            begin
                ref_next = 1'b0;
                st_next = st_tune;
                start_next = 1'b1;
                adaptive_next = 1'b0;
            end
            else if (tuning_selection_in == retune_then_adaptive_option)
            begin
                st_next = st_tune;
                start_next = 1'b1;
                adaptive_next = 1'b1;
            end
        end
        else
        begin
            case (st_reg)
                st_idle:
                begin
                    // self modes tune on enable; strict also on reset
                    if ((sel_reg == tune_self || sel_reg == strict_adaptive_option) &&
                        ((run_rise && !ref_reg) ||
                         (sel_reg == strict_adaptive_option && control_reset_in) ||
                         (ref_reg && run_enable_in && deviation_in)))
                    begin
                        st_next = st_tune;
                        start_next = 1'b1;
                        adaptive_next = 1'b1;
                        ref_next = 1'b0;
                    end
                end
                st_tune:
                begin
                    if (tune_done_in)
                    begin
                        pid_next = 1'b1;
                        if (adaptive_reg)
                        begin
                            st_next = st_acquire;
                            acq_load = 1'b1;
                            blink_next = 32'h0;
                            blink_on_next = 1'b1;
                            if (sel_reg == retune_then_adaptive_option)
                                sel_next = tune_self;
                        end
                        else
                        begin
                            st_next = st_idle;
                            sel_next = tune_off;
                        end
                    end
                end
                st_acquire:
                begin
                    // slow flash divider
                    if (blink_reg >= `BLINK_CYCLES - 32'h1)
                    begin
                        blink_next = 32'h0;
                        blink_on_next = ~blink_on_reg;
                    end
                    else
                        blink_next = blink_reg + 32'h1;
                    if (acq_done)
                    begin
                        st_next = st_idle;
                        ref_next = 1'b1;
                    end
                end
                default: st_next = st_idle;
            endcase
        end
        ind_next = (st_next == st_tune) ||
            (st_next == st_acquire && blink_on_next);
        onoff_next = (st_next == st_tune);
    end

    // tuning registers
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            st_reg <= st_idle;
            sel_reg <= tune_off;
            adaptive_reg <= 1'b0;
            ref_reg <= 1'b0;
            pid_reg <= 1'b0;
            start_reg <= 1'b0;
            ind_reg <= 1'b0;
            onoff_reg <= 1'b0;
            run_d_reg <= 1'b0;
            blink_reg <= 32'h0;
            blink_on_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            sel_reg <= sel_next;
            adaptive_reg <= adaptive_next;
            ref_reg <= ref_next;
            pid_reg <= pid_next;
            start_reg <= start_next;
            ind_reg <= ind_next;
            onoff_reg <= onoff_next;
            run_d_reg <= run_enable_in;
            blink_reg <= blink_next;
            blink_on_reg <= blink_on_next;
        end
    end

    // lockout interval timer
    pulse_timer #(.WIDTH(64)) lock_timer (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .load_in(lock_load),
        .count_in(lock_cnt),
        .busy_out(),
        .done_out(lock_done)
    );

    // acquisition stage timer
    pulse_timer #(.WIDTH(32)) acq_timer (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .load_in(acq_load),
        .count_in(acq_cnt),
        .busy_out(),
        .done_out(acq_done)
    );

    // outputs from flip-flops
    assign edit_accept_out = acc_reg;
    assign edit_reject_out = rej_reg;
    assign code_entry_first_out = first_reg;
    assign unlocked_out = unlock_reg;
    assign lockout_out = lock_reg;
    assign access_code_out = code_reg;
    assign tuning_selection_out = sel_reg;
    assign tuning_indicator_out = ind_reg;
    assign onoff_mode_out = onoff_reg;
    assign pid_load_out = pid_reg;
    assign tune_start_out = start_reg;
    assign ref_valid_out = ref_reg;

    // checks
    property p_reject_locked;
        @(posedge clk_in) disable iff (!reset_n_in)
        (edit_in.valid && !edit_in.is_code_entry && !edit_in.is_code_change &&
         protected_cyc && !unlock_reg) |=> edit_reject_out;
    endproperty
    a_reject_locked: assert property (p_reject_locked) else $error("protected edit taken");
    property p_restricted;
        @(posedge clk_in) disable iff (!reset_n_in)
        (edit_in.valid && edit_in.cycle == `CYCLE_RESTRICTED) |-> protected_cyc;
    endproperty
    a_restricted: assert property (p_restricted) else $error("restricted unprotected");
    property p_lock_entry;
        @(posedge clk_in) disable iff (!reset_n_in)
        (lock_reg && edit_in.valid && edit_in.is_code_entry) |=> (edit_reject_out && !unlocked_out);
    endproperty
    a_lock_entry: assert property (p_lock_entry) else $error("entry during lockout");
    property p_quick_done;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_reg == st_tune && tune_done_in && !adaptive_reg && !tuning_selection_wr_in)
        |=> (tuning_selection_out == tune_off && pid_load_out && !tuning_indicator_out);
    endproperty
    a_quick_done: assert property (p_quick_done) else $error("tune end wrong");
    property p_ind_tune;
        @(posedge clk_in) disable iff (!reset_n_in)
        onoff_mode_out |-> tuning_indicator_out;
    endproperty
    a_ind_tune: assert property (p_ind_tune) else $error("indicator dark in tune");
    property p_user_discard;
        @(posedge clk_in) disable iff (!reset_n_in)
        (tuning_selection_wr_in && tuning_selection_in == tune_full) |=> !ref_valid_out;
    endproperty
    a_user_discard: assert property (p_user_discard) else $error("reference kept");
    property p_retune;
        @(posedge clk_in) disable iff (!reset_n_in)
        (tuning_selection_wr_in && tuning_selection_in == retune_then_adaptive_option)
        |=> (tune_start_out && onoff_mode_out);
    endproperty
    a_retune: assert property (p_retune) else $error("retune not started");
    property p_code_ok;
        @(posedge clk_in) disable iff (!reset_n_in)
        (edit_in.valid && edit_in.is_code_entry && !lock_reg && edit_in.value == code_reg)
        |=> (unlocked_out && wrong_reg == 3'h0);
    endproperty
    a_code_ok: assert property (p_code_ok) else $error("good code refused");
    c_lockout: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(lockout_out));
    c_acquire: cover property (@(posedge clk_in) disable iff (!reset_n_in) acq_done);
    c_unlock: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(unlocked_out));
endmodule

// *** tb/panel_operator.sv ***
// front-panel operator model: steps cycles, edits values, writes tuning selection
// assumes the sequencer takes each request on the rising edge of clk_in
module panel_operator
    import lock_tune_pkg::*;
(
    // clock
    input wire logic clk_in,
    // answers from the sequencer
    input wire logic accept_in,
    input wire logic reject_in,
    // requests to the sequencer
    output edit_req_t edit_out,
    output logic [2:0] view_out,
    output logic [2:0] sel_out,
    output logic sel_wr_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle values: fields unqualified, so not left at a friendly level
    initial
    begin
        edit_out = '{1'b0, 3'h7, 1'b1, 1'b1, 14'h3FFF};
        view_out = 3'h0;
        sel_out = 3'h7;
        sel_wr_out = 1'b0;
    end

    // one edit beat, held to the taking edge, answer read at the next falling edge
    task automatic edit(input logic [2:0] cyc, input logic ent, input logic chg,
                        input logic [13:0] val, output logic ok, output logic bad);
        @(posedge clk_in);
        edit_out <= '{1'b1, cyc, ent, chg, val};
        @(posedge clk_in);
        // released fields scrambled so a stale value cannot be reused
        edit_out <= '{1'b0, ~cyc, ~ent, ~chg, ~val};
        @(negedge clk_in);
        ok = accept_in;
        bad = reject_in;
    endtask

    // step the displayed cycle
    task automatic show(input logic [2:0] cyc);
        @(posedge clk_in);
        view_out <= cyc;
    endtask

    // one write of the tuning selection
    task automatic tune(input logic [2:0] v);
        @(posedge clk_in);
        sel_out <= v;
        sel_wr_out <= 1'b1;
        @(posedge clk_in);
        sel_wr_out <= 1'b0;
        sel_out <= ~v;
    endtask
endmodule

// *** tb/tb_lock_tune_seq.sv ***
// self-checking bench for the configuration lock and auto-tune sequencer
// assumes lockout shortened to LOCK cycles; acquisition = response time * ACQ
module tb_lock_tune_seq
    import lock_tune_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK = 20; // short lockout keeps the run brief
    localparam int ACQ = 4;
    localparam int RT = 10;

    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    edit_req_t edit;
    logic [2:0] view;
    logic [2:0] sel;
    logic sel_wr;
    protection_level_select_t prot = prot_only_restricted;
    logic run = 1'b0;
    logic crst = 1'b0;
    logic done = 1'b0;
    logic dev = 1'b0;
    logic acc, rej, cef, unl, lko, ind, onoff, pidl, tst, refv;
    logic [13:0] code;
    logic [9:0] serial; // low serial digits, changed once for the master code
    logic [23:0] rtime;
    logic [2:0] sel_q;
    logic ok, bad, seen;
    int err_total = 0;
    int cmp_count = 0;
    int starts = 0;
    int snap;

    // 50 MHz clock
    always #10 clk_in = ~clk_in;

    lock_tune_seq #(.LOCKOUT_CYC(LOCK), .ACQ_SCALE(ACQ)) i_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .edit_in(edit), .view_cycle_in(view),
        .serial_low_in(serial), .protection_level_select_in(prot),
        .tuning_selection_in(sel), .tuning_selection_wr_in(sel_wr),
        .run_enable_in(run), .control_reset_in(crst), .tune_done_in(done),
        .deviation_in(dev), .response_time_in(rtime), .edit_accept_out(acc),
        .edit_reject_out(rej), .code_entry_first_out(cef), .unlocked_out(unl),
        .lockout_out(lko), .access_code_out(code), .tuning_selection_out(sel_q),
        .tuning_indicator_out(ind), .onoff_mode_out(onoff), .pid_load_out(pidl),
        .tune_start_out(tst), .ref_valid_out(refv));

    panel_operator i_op (.clk_in(clk_in), .accept_in(acc), .reject_in(rej),
        .edit_out(edit), .view_out(view), .sel_out(sel), .sel_wr_out(sel_wr));

    // count tuning starts for the no-start checks
    always @(negedge clk_in)
        if (tst === 1'b1)
            starts++;

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // code entry in the restricted cycle, answer compared
    task automatic try_code(input logic [13:0] v, input logic exp_ok);
        i_op.edit(3'h6, 1'b1, 1'b0, v, ok, bad);
        chk("code accept", exp_ok, ok);
        chk("code reject", !exp_ok, bad);
    endtask

    // bounded wait for a tuning start pulse
    task automatic wait_start(input int lim);
        seen = 1'b0;
        repeat (lim)
        begin
            @(negedge clk_in);
            if (tst === 1'b1)
                seen = 1'b1;
        end
    endtask

    // tuner reports completion; pid load seen a cycle after
    task automatic finish_tune();
        @(posedge clk_in);
        done <= 1'b1;
        @(posedge clk_in);
        done <= 1'b0;
        @(negedge clk_in);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // protected cycles: restricted always, then a falling lower bound
    function automatic logic guarded(int l, int c);
        return c == 6 || l == 6 || (l >= 1 && c >= 6 - l);
    endfunction

    // watchdog, far above the few hundred cycles the tests take
    initial
    begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        stop_test();
    end

    initial
    begin
        serial <= 10'h141;
        rtime <= 24'(RT);
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(negedge clk_in);
        chk("factory code", 14'd1111, code);
        chk("unlocked", 1'b0, unl);
        // every level against every cycle while locked
        for (int l = 0; l < 7; l++)
        begin
            @(posedge clk_in);
            prot <= protection_level_select_t'(l[2:0]);
            for (int c = 0; c < 7; c++)
            begin
                i_op.edit(c[2:0], 1'b0, 1'b0, 14'h0001, ok, bad);
                chk("edit accept", !guarded(l, c), ok);
                chk("edit reject", guarded(l, c), bad);
            end
        end
        @(posedge clk_in);
        prot <= prot_only_restricted;
        i_op.show(3'h6);
        repeat (2) @(negedge clk_in);
        chk("code first", 1'b1, cef);
        i_op.show(3'h0);
        repeat (2) @(negedge clk_in);
        chk("code first off", 1'b0, cef);
        i_op.show(3'h1);
        prot <= prot_one_six;
        repeat (2) @(negedge clk_in);
        chk("code first level", 1'b1, cef);
        // five wrong codes, then refusal of even the right one
        repeat (5) try_code(14'd1234, 1'b0);
        chk("lockout", 1'b1, lko);
        try_code(14'd1111, 1'b0);
        repeat (LOCK + 5) @(negedge clk_in);
        chk("lockout over", 1'b0, lko);
        repeat (4) try_code(14'd1234, 1'b0);
        chk("count cleared by expiry", 1'b0, lko);
        try_code(14'd1111, 1'b1);
        chk("unlocked", 1'b1, unl);
        repeat (4) try_code(14'd1234, 1'b0);
        chk("count cleared by success", 1'b0, lko);
        try_code(14'd1111, 1'b1);
        i_op.edit(3'h6, 1'b0, 1'b0, 14'h0002, ok, bad);
        chk("unlocked edit", 1'b1, ok);
        i_op.edit(3'h6, 1'b0, 1'b1, 14'd2222, ok, bad);
        chk("code change", 14'd2222, code);
        try_code(14'd1111, 1'b0);
        chk("relocked", 1'b0, unl);
        try_code(14'd2222, 1'b1);
        i_op.edit(3'h6, 1'b0, 1'b1, 14'd0, ok, bad);
        chk("zero code refused", 14'd2222, code);
        try_code(14'd1234, 1'b0);
        @(posedge clk_in);
        serial <= 10'h3E7;
        try_code(14'd9999, 1'b1);
        chk("master only", 1'b0, unl);
        i_op.edit(3'h6, 1'b0, 1'b1, 14'd4321, ok, bad);
        chk("master change", 14'd4321, code);
        // user quick and full tuning
        for (int v = 1; v < 3; v++)
        begin
            i_op.tune(v[2:0]);
            @(negedge clk_in);
            chk("start", 1'b1, tst);
            repeat (5) @(negedge clk_in);
            chk("indicator on", 1'b1, ind);
            chk("onoff", 1'b1, onoff);
            finish_tune();
            chk("pid load", 1'b1, pidl);
            chk("sel off", 3'h0, sel_q);
            chk("indicator off", 1'b0, ind);
            chk("pid mode", 1'b0, onoff);
        end
        // self-adaptive: tune on enable, then scaled acquisition
        i_op.tune(3'h3);
        @(posedge clk_in);
        run <= 1'b1;
        wait_start(5);
        chk("self start", 1'b1, seen);
        finish_tune();
        repeat (RT * ACQ - 6) @(negedge clk_in);
        chk("acquiring", 1'b0, refv);
        repeat (12) @(negedge clk_in);
        chk("ref held", 1'b1, refv);
        chk("indicator idle", 1'b0, ind);
        // re-enable with reference held: no tuning
        snap = starts;
        @(posedge clk_in);
        run <= 1'b0;
        repeat (3) @(posedge clk_in);
        run <= 1'b1;
        repeat (10) @(negedge clk_in);
        chk("no start", snap, starts);
        // control reset in self mode does nothing; strict tunes
        @(posedge clk_in);
        crst <= 1'b1;
        @(posedge clk_in);
        crst <= 1'b0;
        repeat (10) @(negedge clk_in);
        chk("self ignores reset", snap, starts);
        i_op.tune(3'h5);
        @(posedge clk_in);
        crst <= 1'b1;
        @(posedge clk_in);
        crst <= 1'b0;
        wait_start(5);
        chk("strict start", 1'b1, seen);
        finish_tune();
        repeat (RT * ACQ + 6) @(negedge clk_in);
        // deviation retunes and reacquires
        @(posedge clk_in);
        dev <= 1'b1;
        wait_start(5);
        chk("deviation start", 1'b1, seen);
        chk("ref cleared", 1'b0, refv);
        @(posedge clk_in);
        dev <= 1'b0;
        finish_tune();
        repeat (RT * ACQ + 6) @(negedge clk_in);
        chk("fresh ref", 1'b1, refv);
        i_op.tune(3'h1);
        repeat (2) @(negedge clk_in);
        chk("ref discarded", 1'b0, refv);
        finish_tune();
        // retune option ends in self-adaptive
        i_op.tune(3'h4);
        @(negedge clk_in);
        chk("retune start", 1'b1, tst);
        finish_tune();
        @(negedge clk_in);
        chk("sel self", 3'h3, sel_q);
        stop_test();
    end
endmodule
